// ===== verilog/rcl_pkg.sv
// rcl_pkg: constants, opcode encodings, request/result carriers and timing for the
// rotate-through-carry-left unit. assumes nothing of its surroundings.
package rcl_pkg;
    // ------------------------------------------------------------
    // opcodes and reg field
    // ------------------------------------------------------------
    localparam logic [7:0] RCL_OP_B1 = 8'hD0;
    localparam logic [7:0] RCL_OP_W1 = 8'hD1;
    localparam logic [7:0] RCL_OP_BCNT = 8'hD2;
    localparam logic [7:0] RCL_OP_WCNT = 8'hD3;
    localparam logic [7:0] RCL_OP_BIMM = 8'hC0;
    localparam logic [7:0] RCL_OP_WIMM = 8'hC1;
    localparam logic [2:0] RCL_REG_FIELD = 3'h2;
    // ------------------------------------------------------------
    // count and timing
    // ------------------------------------------------------------
    localparam int RCL_CNT_BITS = 5;
    localparam logic [4:0] RCL_CNT_ONE = 5'h01;
    localparam logic [4:0] RCL_CNT_ZERO = 5'h00;
    localparam logic [5:0] RCL_CYC_ONE_REG = 6'h02;
    localparam logic [5:0] RCL_CYC_ONE_MEM = 6'h0F;
    localparam logic [5:0] RCL_CYC_N_REG = 6'h05;
    localparam logic [5:0] RCL_CYC_N_MEM = 6'h11;
    localparam logic [5:0] RCL_CYC_ONE = 6'h01;
    localparam logic [5:0] RCL_CYC_ZERO = 6'h00;
    localparam int RCL_BYTE_MSB = 7;
    localparam int RCL_WORD_MSB = 15;
    // ------------------------------------------------------------
    // carriers
    // ------------------------------------------------------------
    typedef enum logic [1:0] {RCL_SRC_ONE, RCL_SRC_IMM, RCL_SRC_CNTREG} rcl_src_e;
    typedef enum {RCL_IDLE, RCL_BUSY} rcl_state_e;
    typedef struct packed {
        logic [7:0] opcode;
        logic [2:0] reg_field;
        logic is_mem;
        logic [15:0] operand;
        logic [7:0] immediate_byte_count;
        logic [7:0] count_register_low;
        logic carry_flag;
        logic overflow_flag;
    } rcl_req_s;
    typedef struct packed {
        logic [15:0] result;
        logic carry_flag;
        logic overflow_flag;
        logic flags_written;
    } rcl_res_s;
endpackage : rcl_pkg

// ===== verilog/rcl_unit.sv
// rcl_unit: rotate-through-carry-left datapath, flags and cycle timing.
// assumes the core holds req stable only in the start cycle; flags other than carry and
// overflow are kept by the core and never driven here.
`timescale 1ns/1ps
module rcl_unit
    import rcl_pkg::*;
(
    input wire logic ref_clk,
    input wire logic reset,
    input wire logic start,
    input wire rcl_req_s req,
    output logic busy,
    output logic accept_err,
    output logic done,
    output rcl_res_s res
);
    // ------------------------------------------------------------
    // decode
    // ------------------------------------------------------------
    typedef struct packed {
        rcl_state_e state;
        logic [5:0] cyc_left;
        rcl_res_s res;
        logic done;
        logic [5:0] age;
    } rcl_st_s;

    rcl_st_s st_ff;
    rcl_st_s nxt_st;

    function automatic logic is_word(input logic [7:0] op);
        is_word = (op == RCL_OP_W1) || (op == RCL_OP_WCNT) || (op == RCL_OP_WIMM);
    endfunction : is_word

    function automatic logic is_ours(input logic [7:0] op, input logic [2:0] rf);
        is_ours = (rf == RCL_REG_FIELD) && ((op == RCL_OP_B1) || (op == RCL_OP_BCNT)
            || (op == RCL_OP_BIMM) || is_word(op));
    endfunction : is_ours

    function automatic rcl_src_e src_of(input logic [7:0] op);
        if ((op == RCL_OP_B1) || (op == RCL_OP_W1)) begin
            src_of = RCL_SRC_ONE;
        end else if ((op == RCL_OP_BIMM) || (op == RCL_OP_WIMM)) begin
            src_of = RCL_SRC_IMM;
        end else begin
            src_of = RCL_SRC_CNTREG;
        end
    endfunction : src_of

    logic [4:0] cnt;
    logic word;
    logic valid;
    logic [16:0] rot;
    logic [16:0] step;
    logic new_carry;
    logic new_msb;

    always_comb begin
        word = is_word(req.opcode);
        valid = is_ours(req.opcode, req.reg_field);
        case (src_of(req.opcode))
            RCL_SRC_ONE: cnt = RCL_CNT_ONE;
            RCL_SRC_IMM: cnt = req.immediate_byte_count[RCL_CNT_BITS-1:0];
            default: cnt = req.count_register_low[RCL_CNT_BITS-1:0];
        endcase
    end

    // ------------------------------------------------------------
    // rotator: one step per stage, unrolled to the 5-bit maximum
    // ------------------------------------------------------------
    // a combinational rotator keeps the result ready in the start cycle; the cycle count
    // is then only a delay, which is cheaper than a real bit-serial loop at 31 steps
    always_comb begin
        rot = word ? {req.carry_flag, req.operand}
                   : {8'h00, req.carry_flag, req.operand[RCL_BYTE_MSB:0]};
        for (int i = 0; i < (1 << RCL_CNT_BITS) - 1; i++) begin
            if (i < int'(cnt)) begin
                if (word) begin
                    step = {rot[15:0], rot[16]};
                end else begin
                    step = {8'h00, rot[7:0], rot[8]};
                end
                rot = step;
            end
        end
        step = rot;
        new_carry = word ? rot[16] : rot[8];
        new_msb = word ? rot[RCL_WORD_MSB] : rot[RCL_BYTE_MSB];
    end

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    always_comb begin
        nxt_st = st_ff;
        nxt_st.done = 1'b0;
        case (st_ff.state)
            RCL_IDLE: begin
                if (start && valid) begin
                    nxt_st.res.result = word ? rot[15:0] : {req.operand[15:8], rot[7:0]};
                    if (cnt == RCL_CNT_ZERO) begin
                        nxt_st.res.result = req.operand;
                        nxt_st.res.carry_flag = req.carry_flag;
                        nxt_st.res.overflow_flag = req.overflow_flag;
                        nxt_st.res.flags_written = 1'b0;
                        nxt_st.cyc_left = req.is_mem ? RCL_CYC_N_MEM : RCL_CYC_N_REG;
                    end else if (cnt == RCL_CNT_ONE) begin
                        nxt_st.res.carry_flag = new_carry;
                        nxt_st.res.overflow_flag = new_msb ^ new_carry;
                        nxt_st.res.flags_written = 1'b1;
                        nxt_st.cyc_left = req.is_mem ? RCL_CYC_ONE_MEM : RCL_CYC_ONE_REG;
                    end else begin
                        nxt_st.res.carry_flag = new_carry;
                        // overflow is undefined here; holding the old value is cheapest
                        nxt_st.res.overflow_flag = req.overflow_flag;
                        nxt_st.res.flags_written = 1'b1;
                        nxt_st.cyc_left = (req.is_mem ? RCL_CYC_N_MEM : RCL_CYC_N_REG)
                            + {1'b0, cnt};
                    end
                    nxt_st.cyc_left = nxt_st.cyc_left - RCL_CYC_ONE;
                    nxt_st.age = RCL_CYC_ONE;
                    nxt_st.state = RCL_BUSY;
                end
            end
            RCL_BUSY: begin
                nxt_st.age = st_ff.age + RCL_CYC_ONE;
                if (st_ff.cyc_left == RCL_CYC_ONE) begin
                    nxt_st.done = 1'b1;
                    nxt_st.state = RCL_IDLE;
                    nxt_st.cyc_left = RCL_CYC_ZERO;
                end else begin
                    nxt_st.cyc_left = st_ff.cyc_left - RCL_CYC_ONE;
                end
            end
            default: nxt_st.state = RCL_IDLE;
        endcase
    end

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            st_ff <= '{state: RCL_IDLE, cyc_left: RCL_CYC_ZERO, res: '0, done: 1'b0,
                age: RCL_CYC_ZERO};
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign busy = (st_ff.state == RCL_BUSY);
    assign accept_err = start && (!valid || busy);
    assign done = st_ff.done;
    assign res = st_ff.res;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (reset);

    AST_ONE_REG_TIME: assert property (
        (start && !busy && valid && cnt == RCL_CNT_ONE && !req.is_mem) |=> !done ##1 done)
        else $error("single register rotate not done in 2 cycles");
    // age counts cycles since the take apart from cyc_left, so the long timing check
    // does not lean on the down-counter that it guards
    AST_ONE_MEM_TIME: assert property (
        (start && !busy && valid && cnt == RCL_CNT_ONE && req.is_mem)
        |-> ##15 (done && st_ff.age == RCL_CYC_ONE_MEM))
        else $error("single memory rotate not done in 15 cycles");
    AST_MULTI_REG_TIME: assert property (
        (start && !busy && valid && cnt == 5'h03 && !req.is_mem) |=> !done [*7] ##1 done)
        else $error("three-step register rotate not done in 8 cycles");
    AST_ZERO_KEEP: assert property (
        (start && !busy && valid && cnt == RCL_CNT_ZERO) |=>
        (res.carry_flag == $past(req.carry_flag) && res.overflow_flag == $past(req.overflow_flag)
        && res.result == $past(req.operand) && !res.flags_written))
        else $error("zero count changed flags or operand");
    AST_MASK_ZERO: assert property (
        (start && !busy && valid && src_of(req.opcode) == RCL_SRC_CNTREG
        && req.count_register_low == 8'h20) |=> !res.flags_written)
        else $error("count of 32 not treated as zero");
    AST_OVF_ONE: assert property (
        (start && !busy && valid && cnt == RCL_CNT_ONE) |=>
        res.overflow_flag == (res.carry_flag ^ (is_word($past(req.opcode)) ?
        res.result[RCL_WORD_MSB] : res.result[RCL_BYTE_MSB])))
        else $error("single rotate overflow wrong");
    AST_CF_ONE: assert property (
        (start && !busy && valid && cnt == RCL_CNT_ONE && word) |=>
        res.carry_flag == $past(req.operand[RCL_WORD_MSB])
        && res.result[0] == $past(req.carry_flag))
        else $error("single word rotate carry path wrong");
    AST_BYTE_HIGH: assert property (
        (start && !busy && valid && !word) |=>
        res.result[15:8] == $past(req.operand[15:8]))
        else $error("byte rotate disturbed high byte");
    AST_WORD_FULL: assert property (
        (start && !busy && valid && word && cnt == 5'h11) |=>
        res.result == $past(req.operand) && res.carry_flag == $past(req.carry_flag))
        else $error("seventeen-step word rotate not identity");
    AST_BUSY_HOLD: assert property (
        busy && !done |=> $stable(res))
        else $error("result changed while busy");
    AST_ZERO_TIME: assert property (
        (start && !busy && valid && cnt == RCL_CNT_ZERO && !req.is_mem)
        |=> !done [*4] ##1 done)
        else $error("zero count register rotate not done in 5 cycles");
    AST_BAD_IGNORED: assert property (
        (start && !busy && !valid) |=> !busy && $stable(res))
        else $error("invalid form was taken");

    COV_ONE: cover property (start && !busy && valid && cnt == RCL_CNT_ONE);
    COV_IMM: cover property (start && !busy && valid && src_of(req.opcode) == RCL_SRC_IMM);
    COV_ZERO: cover property (start && !busy && valid && cnt == RCL_CNT_ZERO);
    COV_MEM: cover property (start && !busy && valid && req.is_mem && cnt > RCL_CNT_ONE);
    COV_REFUSE: cover property (start && busy);
endmodule : rcl_unit

// ===== test/tb.sv
// tb: self-checking bench for rcl_unit, driven at the falling edge.
// assumes the unit's own assertions stand in its file; no partner is needed.
`timescale 1ns/1ps
`define CHK(nm, exp, got) begin checks++; if ((got) !== (exp)) begin \
    $display("[FAIL] %s exp=%h got=%h", nm, exp, got); error_cnt++; end end
module tb;
    import rcl_pkg::*;
    logic ref_clk = 1'b0;
    logic reset = 1'b1;
    logic start = 1'b0;
    rcl_req_s req = '0;
    logic busy;
    logic accept_err;
    logic done;
    rcl_res_s res;
    int error_cnt = 0;
    int checks = 0;
    rcl_unit dut (.ref_clk(ref_clk), .reset(reset), .start(start), .req(req), .busy(busy),
        .accept_err(accept_err), .done(done), .res(res));
    initial begin
        forever #10 ref_clk = ~ref_clk;
    end
    // ----------------------------------------------------------------
    // reference model
    // ----------------------------------------------------------------
    function automatic logic is_byte(input rcl_req_s r);
        return r.opcode inside {RCL_OP_B1, RCL_OP_BCNT, RCL_OP_BIMM};
    endfunction : is_byte
    function automatic logic [4:0] cnt(input rcl_req_s r);
        if (r.opcode inside {RCL_OP_B1, RCL_OP_W1}) return 5'h01;
        if (r.opcode inside {RCL_OP_BIMM, RCL_OP_WIMM}) return r.immediate_byte_count[4:0];
        return r.count_register_low[4:0];
    endfunction : cnt
    function automatic rcl_res_s model(input rcl_req_s r);
        rcl_res_s e;
        logic [16:0] v;
        logic [4:0] n;
        n = cnt(r);
        v = is_byte(r) ? {8'h00, r.carry_flag, r.operand[7:0]} : {r.carry_flag, r.operand};
        for (int i = 0; i < n; i++) begin
            if (is_byte(r)) v[8:0] = {v[7:0], v[8]};
            else v = {v[15:0], v[16]};
        end
        e.result = is_byte(r) ? {r.operand[15:8], v[7:0]} : v[15:0];
        e.carry_flag = is_byte(r) ? v[8] : v[16];
        e.overflow_flag = r.overflow_flag;
        if (n == 5'h01) e.overflow_flag = e.carry_flag ^ (is_byte(r) ? v[7] : v[15]);
        e.flags_written = (n != 5'h00);
        return e;
    endfunction : model
    function automatic int cycles(input rcl_req_s r);
        if (cnt(r) == 5'h01) return r.is_mem ? 15 : 2;
        return (r.is_mem ? 17 : 5) + int'(cnt(r));
    endfunction : cycles
    function automatic rcl_req_s mk(input logic [7:0] op, input logic mem,
        input logic [15:0] d, input logic [7:0] imm, input logic [7:0] cnt_reg,
        input logic cy_in, input logic ov_in);
        return '{op, RCL_REG_FIELD, mem, d, imm, cnt_reg, cy_in, ov_in};
    endfunction : mk
    // ----------------------------------------------------------------
    // shared transfer and closing
    // ----------------------------------------------------------------
    task automatic finish_test;
        $display("checks=%0d errors=%0d", checks, error_cnt);
        if (error_cnt == 0 && checks > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask : finish_test
    // poke strobes a second start in cycle 2, which must be refused while busy
    task automatic run_op(input rcl_req_s r, input bit poke);
        rcl_res_s e;
        int k;
        e = model(r);
        req = r;
        start = 1'b1;
        #1;
        `CHK("accept", 1'b0, accept_err)
        @(negedge ref_clk);
        start = 1'b0;
        `CHK("busy", 1'b1, busy)
        k = 1;
        while (done !== 1'b1 && k < 100) begin
            @(negedge ref_clk);
            k++;
            start = poke && k == 2;
            #1;
            if (start) `CHK("refuse", 1'b1, accept_err)
        end
        start = 1'b0;
        if (k >= 100) begin
            error_cnt++;
            finish_test();
        end
        `CHK("cycles", cycles(r), k)
        `CHK("busy_end", 1'b0, busy)
        `CHK("result", e.result, res.result)
        `CHK("carry", e.carry_flag, res.carry_flag)
        `CHK("overflow", e.overflow_flag, res.overflow_flag)
        `CHK("written", e.flags_written, res.flags_written)
        @(negedge ref_clk);
        `CHK("done_pulse", 1'b0, done)
    endtask : run_op
    // ----------------------------------------------------------------
    // scenarios
    // ----------------------------------------------------------------
    task automatic sc_single;
        run_op(mk(RCL_OP_B1, 1'b0, 16'hA5C3, 8'h00, 8'h00, 1'b0, 1'b0), 1'b0);
        run_op(mk(RCL_OP_B1, 1'b1, 16'h1240, 8'h00, 8'h00, 1'b1, 1'b1), 1'b0);
        run_op(mk(RCL_OP_W1, 1'b1, 16'h4889, 8'h00, 8'h00, 1'b1, 1'b1), 1'b0);
        `CHK("word_known", 16'h9113, res.result)
    endtask : sc_single
    task automatic sc_counts;
        run_op(mk(RCL_OP_BCNT, 1'b0, 16'h3C81, 8'h00, 8'h09, 1'b1, 1'b0), 1'b0);
        run_op(mk(RCL_OP_BIMM, 1'b1, 16'h00F7, 8'hFF, 8'h00, 1'b0, 1'b1), 1'b1);
        run_op(mk(RCL_OP_WIMM, 1'b1, 16'h8001, 8'h25, 8'h00, 1'b1, 1'b0), 1'b0);
        run_op(mk(RCL_OP_BCNT, 1'b0, 16'h0055, 8'h00, 8'hE3, 1'b1, 1'b0), 1'b0);
        run_op(mk(RCL_OP_WIMM, 1'b0, 16'hC0DE, 8'h11, 8'h00, 1'b0, 1'b1), 1'b0);
    endtask : sc_counts
    task automatic sc_zero;
        run_op(mk(RCL_OP_WCNT, 1'b0, 16'hBEEF, 8'h00, 8'h20, 1'b1, 1'b1), 1'b0);
        run_op(mk(RCL_OP_WCNT, 1'b1, 16'h1234, 8'h00, 8'h00, 1'b0, 1'b1), 1'b0);
    endtask : sc_zero
    task automatic sc_invalid;
        req = mk(RCL_OP_B1, 1'b0, 16'h0001, 8'h00, 8'h00, 1'b0, 1'b0);
        req.reg_field = 3'h3;
        start = 1'b1;
        #1;
        `CHK("bad_form", 1'b1, accept_err)
        @(negedge ref_clk);
        start = 1'b0;
        `CHK("bad_idle", 1'b0, busy)
        @(negedge ref_clk);
        req.opcode = 8'hD4;
        req.reg_field = RCL_REG_FIELD;
        start = 1'b1;
        #1;
        `CHK("bad_op", 1'b1, accept_err)
        @(negedge ref_clk);
        start = 1'b0;
        `CHK("bad_op_idle", 1'b0, busy)
    endtask : sc_invalid
    initial begin
        repeat (5) @(negedge ref_clk);
        reset = 1'b0;
        `CHK("reset_res", 19'h00000, res)
        `CHK("reset_busy", 1'b0, busy)
        `CHK("reset_done", 1'b0, done)
        sc_single();
        sc_counts();
        sc_zero();
        sc_invalid();
        @(negedge ref_clk);
        finish_test();
    end
endmodule : tb
